// >>> hw/pcc_byte_count.sv
// total byte count of a request from its byte masks and dword count
// assumes masks copied from the request as received
`timescale 1ns/10ps
module pcc_byte_count
    import pcc_pkg::*;
(
    pcc_calc_if.calc calc
);
    function automatic logic [1:0] lead_off(input logic [3:0] m);
        lead_off = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
    endfunction

    function automatic logic [1:0] trail_off(input logic [3:0] m);
        trail_off = m[3] ? 2'h0 : m[2] ? 2'h1 : m[1] ? 2'h2 : 2'h3;
    endfunction

    logic [12:0] full_bytes;

    assign full_bytes = {calc.dw_count[10:0], 2'h0};

    always_comb
    begin
        calc.lead = (calc.first_mask == 4'h0) ? 2'h0 : lead_off(calc.first_mask);
        if (calc.last_mask == 4'h0)
        begin
            // single dword: span between outermost enabled bytes, empty mask still counts one
            if (calc.first_mask == 4'h0)
                calc.total_bytes = 13'h0001;
            else
                calc.total_bytes = 13'(3'h4 - {1'b0, trail_off(calc.first_mask)}
                    - {1'b0, lead_off(calc.first_mask)});
        end
        else
        begin
            calc.total_bytes = full_bytes - 13'(lead_off(calc.first_mask))
                - 13'(trail_off(calc.last_mask));
        end
    end
endmodule

// >>> hw/pcc_calc_if.sv
// request byte masks and dword count toward the calculator, byte figures back
// assumes one clock domain; purely combinational traffic
`timescale 1ns/10ps
interface pcc_calc_if;
    logic [3:0] first_mask;
    logic [3:0] last_mask;
    logic [10:0] dw_count;
    logic [12:0] total_bytes;
    logic [1:0] lead;
    modport src (output first_mask, output last_mask, output dw_count, input total_bytes, input lead);
    modport calc (input first_mask, input last_mask, input dw_count, output total_bytes, output lead);
endinterface

// >>> hw/pcc_cmpl_sender.sv
// completion sender: builds completion descriptors and sends them with payload as stream packets
// assumes a 64-bit completion stream on i_clk, dword-aligned mode, payload of at most 8 dwords
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
`include "pcc_defs.svh"
// Functional notes
// - lower address only for memory reads
// - address type only for memory, atomics
// - byte count four for io completions
// - zero-length read: count one, dummy dword
// - byte count holds remaining bytes per split
// - locked bit only for locked reads
// - dword count by kind and status
// - status is SC, UR or CA
// - poison only when software flags bad data
// - copy requester id, tag, traffic class
// - function number always, eight bits with ARI
// - device number with override when supplied, without ARI
// - bus number with override when supplied
// - copy attribute bits from request
// - total bytes from masks and dword count
// - one or more completions per non-posted request
// - split by max payload, own descriptor
// - payload starts after descriptor, whole dwords
// - payload dwords passed as written, gaps not nulled
// - descriptor fills first beat and low dword of second
// - valid held through whole packet
module pcc_cmpl_sender
    import pcc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    input wire logic i_cc_tready,
    output logic [63:0] o_cc_tdata,
    output logic [1:0] o_cc_tkeep,
    output logic o_cc_tlast,
    output logic o_cc_tvalid,
    output logic o_busy
);
    pcc_main_type st_ff;
    pcc_main_type nxt_st;
    pcc_calc_if u_calc_if();

    pcc_byte_count u_byte_count
    (
        .calc (u_calc_if.calc)
    );

    assign u_calc_if.first_mask = st_ff.first_mask;
    assign u_calc_if.last_mask = st_ff.last_mask;
    assign u_calc_if.dw_count = st_ff.dw_count;

    function automatic logic [2:0] stat_code(input logic [1:0] sel);
        case (sel)
            2'h0: stat_code = `PCC_STAT_SC;
            2'h1: stat_code = `PCC_STAT_UR;
            default: stat_code = `PCC_STAT_CA;
        endcase
    endfunction

    function automatic logic [10:0] min_dw(input logic [10:0] a, input logic [3:0] lim);
        logic [10:0] l;
        l = (lim == 4'h0 || lim > `PCC_PAY_MAX) ? 11'(`PCC_PAY_MAX) : 11'(lim);
        min_dw = (a < l) ? a : l;
    endfunction

    // dword j of the packet: descriptor first, payload right behind it
    function automatic logic [31:0] pkt_dw(input pcc_main_type s, input logic [3:0] j);
        logic [10:0] idx;
        idx = s.sent_dw + 11'(j) - 11'h003;
        case (j)
            4'h0: pkt_dw = s.desc[31:0];
            4'h1: pkt_dw = s.desc[63:32];
            4'h2: pkt_dw = s.desc[95:64];
            default: pkt_dw = s.pay[idx[2:0]];
        endcase
    endfunction

    logic zero_len;
    logic is_sc;
    logic [10:0] ld_dc;
    logic [12:0] ld_bc;
    logic [6:0] ld_la;
    logic [6:0] split_la;
    logic [3:0] ld_tot;
    logic [12:0] consumed;
    logic [10:0] rem_dw_next;
    logic [3:0] j0;
    logic [3:0] j1;
    logic [3:0] tot_dw;
    logic load_beat;

    assign zero_len = (st_ff.first_mask == 4'h0) && (st_ff.last_mask == 4'h0);
    assign is_sc = (st_ff.stat_sel == 2'h0);
    assign tot_dw = 4'h3 + st_ff.cur_dc[3:0];
    assign j0 = {st_ff.beat, 1'b0};
    assign j1 = {st_ff.beat, 1'b1};
    assign load_beat = !st_ff.cc_valid || (i_cc_tready && !st_ff.cc_last);
    assign split_la = 7'({st_ff.addr_lo[6:2], 2'h0} + {st_ff.sent_dw[4:0], 2'h0});

    always_comb
    begin
        ld_dc = 11'h000;
        ld_bc = 13'h0000;
        ld_la = 7'h00;
        case (st_ff.kind)
            kind_mem_rd:
            begin
                ld_la = st_ff.first_cmpl ? {st_ff.addr_lo[6:2], u_calc_if.lead} : split_la;
                if (zero_len)
                begin
                    ld_dc = is_sc ? 11'h001 : 11'h000;
                    ld_bc = `PCC_ZL_BCNT;
                end
                else
                begin
                    ld_dc = is_sc ? min_dw(st_ff.rem_dw, st_ff.max_pl) : 11'h000;
                    ld_bc = st_ff.rem_bytes;
                end
            end
            kind_io_rd, kind_cfg_rd:
            begin
                ld_dc = is_sc ? 11'h001 : 11'h000;
                ld_bc = `PCC_IO_BCNT;
            end
            kind_io_wr, kind_cfg_wr:
            begin
                ld_dc = 11'h000;
                ld_bc = `PCC_IO_BCNT;
            end
            kind_atomic:
            begin
                ld_dc = is_sc ? min_dw(st_ff.dw_count, `PCC_PAY_MAX) : 11'h000;
                ld_bc = u_calc_if.total_bytes;
            end
            default:
            begin
                ld_dc = 11'h000;
                ld_bc = 13'h0000;
            end
        endcase
        ld_tot = 4'h3 + ld_dc[3:0];
        consumed = st_ff.first_cmpl ? 13'({st_ff.cur_dc, 2'h0} - 13'(st_ff.cmpl_cnt[0] & 1'b0) - 13'(u_calc_if.lead))
            : 13'({st_ff.cur_dc, 2'h0});
        rem_dw_next = (st_ff.rem_dw > st_ff.cur_dc) ? st_ff.rem_dw - st_ff.cur_dc : 11'h000;
    end

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rdata = 32'h0000_0000;
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                `PCC_A_CTRL: nxt_st.rdata = {20'h0_0000, st_ff.max_pl, 4'h0, st_ff.poison, st_ff.stat_sel, 1'b0};
                `PCC_A_REQID: nxt_st.rdata = {8'h00, st_ff.tag, st_ff.req_id};
                `PCC_A_ATTR: nxt_st.rdata = {17'h0_0000, st_ff.ari, st_ff.cid_ovr, st_ff.ecrc, st_ff.attr,
                    st_ff.tc, st_ff.atype, st_ff.locked, st_ff.kind};
                `PCC_A_CID: nxt_st.rdata = {11'h000, st_ff.bus, st_ff.dev, st_ff.func};
                `PCC_A_ADDR: nxt_st.rdata = {5'h00, st_ff.dw_count, st_ff.last_mask, st_ff.first_mask,
                    1'b0, st_ff.addr_lo};
                `PCC_A_STATUS: nxt_st.rdata = {16'h0000, st_ff.cmpl_cnt, 7'h00, (st_ff.state != st_idle)};
                default:
                begin
                    if (i_reg_addr >= `PCC_A_PAY && i_reg_addr <= `PCC_A_PAY_END && i_reg_addr[1:0] == 2'h0)
                        nxt_st.rdata = st_ff.pay[i_reg_addr[4:2]];
                    else
                        nxt_st.rdata = 32'h0000_0000;
                end
            endcase
        end
        // request fields are frozen while a request is in flight
        if (i_reg_wr && st_ff.state == st_idle)
        begin
            case (i_reg_addr)
                `PCC_A_CTRL:
                begin
                    nxt_st.stat_sel = i_reg_wdata[`PCC_C_STSEL];
                    nxt_st.poison = i_reg_wdata[`PCC_C_POISON];
                    nxt_st.max_pl = i_reg_wdata[`PCC_C_MAXPL];
                    if (i_reg_wdata[`PCC_C_START])
                        nxt_st.state = st_load;
                end
                `PCC_A_REQID:
                begin
                    nxt_st.req_id = i_reg_wdata[`PCC_R_ID];
                    nxt_st.tag = i_reg_wdata[`PCC_R_TAG];
                end
                `PCC_A_ATTR:
                begin
                    nxt_st.kind = pcc_kind_type'(i_reg_wdata[`PCC_T_KIND]);
                    nxt_st.locked = i_reg_wdata[`PCC_T_LOCK];
                    nxt_st.atype = i_reg_wdata[`PCC_T_ATYPE];
                    nxt_st.tc = i_reg_wdata[`PCC_T_TC];
                    nxt_st.attr = i_reg_wdata[`PCC_T_ATTR];
                    nxt_st.ecrc = i_reg_wdata[`PCC_T_ECRC];
                    nxt_st.cid_ovr = i_reg_wdata[`PCC_T_CIDOVR];
                    nxt_st.ari = i_reg_wdata[`PCC_T_ARI];
                end
                `PCC_A_CID:
                begin
                    nxt_st.func = i_reg_wdata[`PCC_I_FUNC];
                    nxt_st.dev = i_reg_wdata[`PCC_I_DEV];
                    nxt_st.bus = i_reg_wdata[`PCC_I_BUS];
                end
                `PCC_A_ADDR:
                begin
                    nxt_st.addr_lo = i_reg_wdata[`PCC_M_ADDR];
                    nxt_st.first_mask = i_reg_wdata[`PCC_M_FIRST];
                    nxt_st.last_mask = i_reg_wdata[`PCC_M_LAST];
                    nxt_st.dw_count = i_reg_wdata[`PCC_M_DWCNT];
                end
                default:
                begin
                    if (i_reg_addr >= `PCC_A_PAY && i_reg_addr <= `PCC_A_PAY_END && i_reg_addr[1:0] == 2'h0)
                        nxt_st.pay[i_reg_addr[4:2]] = i_reg_wdata;
                end
            endcase
            if (i_reg_addr == `PCC_A_CTRL && i_reg_wdata[`PCC_C_START])
            begin
                nxt_st.rem_dw = st_ff.dw_count;
                nxt_st.rem_bytes = u_calc_if.total_bytes;
                nxt_st.sent_dw = 11'h000;
                nxt_st.first_cmpl = 1'b1;
            end
        end
        case (st_ff.state)
            st_idle:
            begin
            end
            st_load:
            begin
                nxt_st.cur_dc = ld_dc;
                nxt_st.beat = 3'h0;
                nxt_st.nbeats = 3'((ld_tot + 4'h1) >> 1);
                nxt_st.desc = 96'h0;
                nxt_st.desc[`PCC_D_LADDR] = ld_la;
                if (st_ff.kind == kind_mem_rd || st_ff.kind == kind_atomic)
                    nxt_st.desc[`PCC_D_ATYPE] = st_ff.atype;
                nxt_st.desc[`PCC_D_BCNT] = ld_bc;
                nxt_st.desc[`PCC_D_LOCK] = st_ff.locked && st_ff.kind == kind_mem_rd;
                nxt_st.desc[`PCC_D_DWCNT] = ld_dc;
                nxt_st.desc[`PCC_D_STAT] = stat_code(st_ff.stat_sel);
                nxt_st.desc[`PCC_D_POISON] = st_ff.poison && ld_dc != 11'h000;
                nxt_st.desc[`PCC_D_REQID] = st_ff.req_id;
                nxt_st.desc[`PCC_D_TAG] = st_ff.tag;
                if (st_ff.ari)
                    nxt_st.desc[`PCC_D_FUNC] = st_ff.func;
                else
                begin
                    nxt_st.desc[`PCC_D_FUNC3] = st_ff.func[2:0];
                    if (st_ff.cid_ovr)
                        nxt_st.desc[`PCC_D_DEV] = st_ff.dev;
                end
                if (st_ff.cid_ovr)
                    nxt_st.desc[`PCC_D_BUS] = st_ff.bus;
                nxt_st.desc[`PCC_D_CIDEN] = st_ff.cid_ovr;
                nxt_st.desc[`PCC_D_TC] = st_ff.tc;
                nxt_st.desc[`PCC_D_ATTR] = st_ff.attr;
                nxt_st.desc[`PCC_D_ECRC] = st_ff.ecrc;
                nxt_st.state = st_send;
            end
            st_send:
            begin
                if (st_ff.cc_valid && i_cc_tready && st_ff.cc_last)
                begin
                    nxt_st.cc_valid = 1'b0;
                    nxt_st.cc_last = 1'b0;
                    nxt_st.state = st_next;
                end
                else if (load_beat)
                begin
                    // valid never drops between beats of one packet
                    nxt_st.cc_valid = 1'b1;
                    nxt_st.cc_data = {pkt_dw(st_ff, j1), pkt_dw(st_ff, j0)};
                    nxt_st.cc_keep = {(j1 < tot_dw), 1'b1};
                    nxt_st.cc_last = (st_ff.beat == st_ff.nbeats - 3'h1);
                    nxt_st.beat = st_ff.beat + 3'h1;
                end
            end
            st_next:
            begin
                nxt_st.cmpl_cnt = st_ff.cmpl_cnt + 8'h01;
                nxt_st.first_cmpl = 1'b0;
                nxt_st.sent_dw = st_ff.sent_dw + st_ff.cur_dc;
                nxt_st.rem_dw = rem_dw_next;
                nxt_st.rem_bytes = (consumed >= st_ff.rem_bytes) ? 13'h0000 : st_ff.rem_bytes - consumed;
                // only successful memory reads split; a zero-length read ends after one
                if (st_ff.kind == kind_mem_rd && is_sc && !zero_len && rem_dw_next != 11'h000
                    && st_ff.cur_dc != 11'h000)
                    nxt_st.state = st_load;
                else
                    nxt_st.state = st_idle;
            end
            default:
            begin
                nxt_st.state = st_idle;
            end
        endcase
        nxt_st.busy = (nxt_st.state != st_idle);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_ff <= '0;
            st_ff.state <= st_idle;
            st_ff.max_pl <= `PCC_RST_MAXPL;
        end
        else if (i_clk_en)
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_reg_rdata = st_ff.rdata;
    assign o_cc_tdata = st_ff.cc_data;
    assign o_cc_tkeep = st_ff.cc_keep;
    assign o_cc_tlast = st_ff.cc_last;
    assign o_cc_tvalid = st_ff.cc_valid;
    assign o_busy = st_ff.busy;

    a_valid_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_cc_tvalid && !i_cc_tready && !o_cc_tlast |=> o_cc_tvalid)
        else $error("valid dropped inside a packet");
    a_data_stable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_cc_tvalid && !i_cc_tready |=> $stable(o_cc_tdata) && $stable(o_cc_tlast))
        else $error("stream changed while stalled");
    a_lower_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff.state == st_send && st_ff.kind != kind_mem_rd |-> st_ff.desc[`PCC_D_LADDR] == 7'h00)
        else $error("lower address set for non memory read");
    a_atype_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff.state == st_send && st_ff.kind inside {kind_io_rd, kind_io_wr, kind_cfg_rd, kind_cfg_wr}
        |-> st_ff.desc[`PCC_D_ATYPE] == 2'h0)
        else $error("address type set for non memory completion");
    a_io_bytes: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff.state == st_load && st_ff.kind inside {kind_io_rd, kind_io_wr}
        |=> st_ff.desc[`PCC_D_BCNT] == 13'h0004)
        else $error("io byte count not four");
    a_zero_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff.state == st_load && st_ff.kind == kind_mem_rd && zero_len && is_sc
        |=> st_ff.desc[`PCC_D_BCNT] == 13'h0001 && st_ff.desc[`PCC_D_DWCNT] == 11'h001 && st_ff.nbeats == 3'h2)
        else $error("zero length read completion malformed");
    a_bytes_shrink: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff.state == st_next && st_ff.rem_bytes != 13'h0000 && st_ff.cur_dc != 11'h000
        |=> st_ff.rem_bytes < $past(st_ff.rem_bytes))
        else $error("remaining byte count did not shrink");
    a_err_no_data: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff.state == st_load && !is_sc |=> st_ff.desc[`PCC_D_DWCNT] == 11'h000 && st_ff.nbeats == 3'h2)
        else $error("error completion carries payload");
    a_status_legal: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff.state == st_send |-> st_ff.desc[`PCC_D_STAT] inside {3'h0, 3'h1, 3'h4})
        else $error("illegal completion status");
    a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff.state == st_send |-> st_ff.desc[`PCC_D_RSV0] == 6'h00 && st_ff.desc[`PCC_D_RSV1] == 2'h0
        && !st_ff.desc[`PCC_D_RSV2])
        else $error("reserved descriptor bits set");
    a_split_limit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_ff.state == st_send |-> st_ff.cur_dc <= 11'(`PCC_PAY_MAX))
        else $error("completion exceeds payload limit");
endmodule

// >>> hw/pcc_defs.svh
// constants for the completion sender: descriptor fields, register map, reset values
// assumes a 64-bit completion stream and 32-bit software registers
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH
`define PCC_D_LADDR 6:0
`define PCC_D_ATYPE 9:8
`define PCC_D_RSV0 15:10
`define PCC_D_BCNT 28:16
`define PCC_D_LOCK 29
`define PCC_D_RSV1 31:30
`define PCC_D_DWCNT 42:32
`define PCC_D_STAT 45:43
`define PCC_D_POISON 46
`define PCC_D_RSV2 47
`define PCC_D_REQID 63:48
`define PCC_D_TAG 71:64
`define PCC_D_FUNC 79:72
`define PCC_D_FUNC3 74:72
`define PCC_D_DEV 79:75
`define PCC_D_BUS 87:80
`define PCC_D_CIDEN 88
`define PCC_D_TC 91:89
`define PCC_D_ATTR 94:92
`define PCC_D_ECRC 95
`define PCC_STAT_SC 3'h0
`define PCC_STAT_UR 3'h1
`define PCC_STAT_CA 3'h4
`define PCC_IO_BCNT 13'h0004
`define PCC_ZL_BCNT 13'h0001
`define PCC_A_CTRL 8'h00
`define PCC_A_REQID 8'h04
`define PCC_A_ATTR 8'h08
`define PCC_A_CID 8'h0c
`define PCC_A_ADDR 8'h10
`define PCC_A_STATUS 8'h14
`define PCC_A_PAY 8'h40
`define PCC_A_PAY_END 8'h5c
`define PCC_C_START 0
`define PCC_C_STSEL 2:1
`define PCC_C_POISON 3
`define PCC_C_MAXPL 11:8
`define PCC_R_ID 15:0
`define PCC_R_TAG 23:16
`define PCC_T_KIND 2:0
`define PCC_T_LOCK 3
`define PCC_T_ATYPE 5:4
`define PCC_T_TC 8:6
`define PCC_T_ATTR 11:9
`define PCC_T_ECRC 12
`define PCC_T_CIDOVR 13
`define PCC_T_ARI 14
`define PCC_I_FUNC 7:0
`define PCC_I_DEV 12:8
`define PCC_I_BUS 20:13
`define PCC_M_ADDR 6:0
`define PCC_M_FIRST 11:8
`define PCC_M_LAST 15:12
`define PCC_M_DWCNT 26:16
`define PCC_RST_MAXPL 4'h8
`define PCC_PAY_MAX 4'h8
`endif

// >>> hw/pcc_pkg.sv
// types shared by the completion sender and its byte count calculator
// assumes pcc_defs.svh for all numeric constants
package pcc_pkg;
    typedef enum logic [2:0] {kind_mem_rd, kind_io_rd, kind_io_wr, kind_atomic, kind_cfg_rd, kind_cfg_wr}
        pcc_kind_type;
    typedef enum logic [1:0] {st_idle, st_load, st_send, st_next} pcc_state_type;
    typedef struct packed {
        pcc_state_type state;
        logic [15:0] req_id;
        logic [7:0] tag;
        pcc_kind_type kind;
        logic locked;
        logic [1:0] atype;
        logic [2:0] tc;
        logic [2:0] attr;
        logic ecrc;
        logic cid_ovr;
        logic ari;
        logic [7:0] func;
        logic [4:0] dev;
        logic [7:0] bus;
        logic [6:0] addr_lo;
        logic [3:0] first_mask;
        logic [3:0] last_mask;
        logic [10:0] dw_count;
        logic [1:0] stat_sel;
        logic poison;
        logic [3:0] max_pl;
        logic [7:0][31:0] pay;
        logic [10:0] rem_dw;
        logic [12:0] rem_bytes;
        logic [10:0] sent_dw;
        logic [10:0] cur_dc;
        logic first_cmpl;
        logic [95:0] desc;
        logic [2:0] beat;
        logic [2:0] nbeats;
        logic [63:0] cc_data;
        logic [1:0] cc_keep;
        logic cc_valid;
        logic cc_last;
        logic [31:0] rdata;
        logic [7:0] cmpl_cnt;
        logic busy;
    } pcc_main_type;
endpackage

// >>> tb/pcc_cmpl_sender_tb.sv
// testbench for the completion sender: packets started over registers, judged at the model
// assumes pcc_defs.svh constants and the stream model in pcc_dev_model.sv
`timescale 1ns/10ps
`include "pcc_defs.svh"
module pcc_cmpl_sender_tb;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_slow = 1'b0;
    logic i_clk_en = 1'b1;
    logic [1:0] keep;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0000_0000;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [31:0] o_reg_rdata;
    logic [63:0] o_cc_tdata;
    logic i_cc_tready, o_cc_tlast, o_cc_tvalid, o_busy, digest;
    logic [7:0] cid_bus;
    int n_mismatch = 0;
    int n_compared = 0;
    always #25 i_clk = ~i_clk;
    pcc_cmpl_sender pcc_cmpl_sender_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_cc_tready(i_cc_tready), .o_cc_tdata(o_cc_tdata), .o_cc_tkeep(keep),
        .o_cc_tlast(o_cc_tlast), .o_cc_tvalid(o_cc_tvalid), .o_busy(o_busy));
    pcc_dev_model pcc_dev_model_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_slow(i_slow),
        .i_cc_tdata(o_cc_tdata), .i_cc_tlast(o_cc_tlast), .i_cc_tvalid(o_cc_tvalid),
        .o_cc_tready(i_cc_tready), .o_cid_bus(cid_bus), .o_digest(digest));
    task automatic chk(input string what, input logic [95:0] seen, input logic [95:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_clk);
        d = o_reg_rdata;
    endtask
    // clears the capture, starts one request and waits for the sender to go idle
    task automatic go(input logic [31:0] ctrl);
        pcc_dev_model_inst.beat_q.delete();
        wr(`PCC_A_CTRL, ctrl);
        // busy only settles after the start edge
        @(negedge i_clk);
        for (int t = 0; t < 300 && o_busy !== 1'b0; t++)
            @(negedge i_clk);
        chk("idle", o_busy, 1'b0);
    endtask
    function automatic logic [95:0] desc(input int b);
        return {pcc_dev_model_inst.beat_q[b + 1][31:0], pcc_dev_model_inst.beat_q[b]};
    endfunction
    function automatic logic [31:0] pay(input int b, input int j);
        return pcc_dev_model_inst.beat_q[b + (3 + j) / 2][((3 + j) % 2) * 32 +: 32];
    endfunction
    function automatic logic [36:0] fields(input logic [95:0] d);
        return {d[`PCC_D_BCNT], d[`PCC_D_DWCNT], d[`PCC_D_LADDR], d[`PCC_D_ATYPE], d[`PCC_D_LOCK], d[`PCC_D_STAT]};
    endfunction
    task automatic t_full;
        i_slow <= 1'b1;
        wr(`PCC_A_REQID, 32'h005a_beef);
        wr(`PCC_A_ATTR, 32'h0000_3b58);
        wr(`PCC_A_CID, 32'h0014_b103);
        wr(`PCC_A_ADDR, 32'h0002_7e24);
        wr(`PCC_A_PAY, 32'h1111_2222);
        wr(`PCC_A_PAY + 8'h04, 32'h3333_4444);
        go(32'h0000_0801);
        chk("desc", desc(0), {1'b1, 3'h5, 3'h5, 1'b1, 8'ha5, 8'h8b, 8'h5a, 16'hbeef, 2'h0, 3'h0, 11'd2,
            2'h0, 1'b1, 13'd6, 6'h0, 2'h1, 1'b0, 7'h25});
        chk("beats", pcc_dev_model_inst.beat_q.size(), 3);
        chk("pay", {pay(0, 0), pay(0, 1)}, 64'h1111_2222_3333_4444);
        chk("cid bus", cid_bus, 8'ha5);
        chk("digest", digest, 1'b1);
        chk("keep", keep, 2'h1);
    endtask
    task automatic t_split;
        logic [31:0] v;
        i_slow <= 1'b0;
        wr(`PCC_A_ATTR, 32'h0000_0000);
        wr(`PCC_A_CID, 32'h0000_0000);
        wr(`PCC_A_ADDR, 32'h0004_ff08);
        wr(`PCC_A_PAY + 8'h08, 32'h5555_6666);
        // frozen clock enable: this write must be lost
        i_clk_en <= 1'b0;
        wr(`PCC_A_PAY + 8'h08, 32'hdead_0000);
        i_clk_en <= 1'b1;
        go(32'h0000_0201);
        chk("split1", fields(desc(0)), {13'd16, 11'd2, 7'h08, 2'd0, 1'b0, 3'd0});
        chk("split2", fields(desc(3)), {13'd8, 11'd2, 7'h10, 2'd0, 1'b0, 3'd0});
        chk("split2 pay", pay(3, 0), 32'h5555_6666);
        rd(`PCC_A_STATUS, v);
        chk("sent", v[15:0], 16'h0300);
    endtask
    task automatic t_kinds;
        logic [12:0] bc[5] = '{13'd4, 13'd4, 13'd16, 13'd4, 13'd4};
        logic [10:0] dc[5] = '{11'd1, 11'd0, 11'd4, 11'd1, 11'd0};
        logic [95:0] d;
        for (int k = 1; k <= 5; k++)
        begin
            wr(`PCC_A_ATTR, 32'h0000_0028 | 32'(k));
            go(32'h0000_0801);
            chk("kind", fields(desc(0)), {bc[k - 1], dc[k - 1], 7'h00, (k == 3) ? 2'd2 : 2'd0, 4'h0});
        end
        wr(`PCC_A_ATTR, 32'h0000_0000);
        for (int s = 1; s <= 2; s++)
        begin
            go(32'h0000_0809 | 32'(s << 1));
            d = desc(0);
            chk("status", {d[`PCC_D_STAT], d[`PCC_D_DWCNT], d[`PCC_D_POISON]}, {(s == 1) ? 3'h1 : 3'h4, 12'h0});
        end
        wr(`PCC_A_ADDR, 32'h0001_0008);
        go(32'h0000_0809);
        d = desc(0);
        chk("zero len", {d[`PCC_D_BCNT], d[`PCC_D_DWCNT], d[`PCC_D_POISON], pay(0, 0)},
            {13'd1, 11'd1, 1'b1, 32'h1111_2222});
        chk("protocol", pcc_dev_model_inst.n_err, 0);
    endtask
    initial
    begin
        #400_000;
        n_mismatch++;
        tally_and_finish;
    end
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_full;
        t_split;
        t_kinds;
        tally_and_finish;
    end
endmodule

// >>> tb/pcc_dev_model.sv
// far-side model: accepts completion stream beats and keeps them in a queue
// assumes one clock; beats are taken at the rising edge with valid and ready high
`timescale 1ns/10ps
module pcc_dev_model
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_slow,
    input wire logic [63:0] i_cc_tdata,
    input wire logic i_cc_tlast,
    input wire logic i_cc_tvalid,
    output logic o_cc_tready,
    output logic [7:0] o_cid_bus,
    output logic o_digest
);
    parameter logic [7:0] CAPT_BUS = 8'h3c; // captured bus number, value arbitrary
    logic [63:0] beat_q[$];
    int n_err = 0;
    int k = 0;
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_cc_tready <= 1'b0;
        else
        begin
            // alternate ready so every beat meets a stall when slow
            o_cc_tready <= i_slow ? ~o_cc_tready : 1'b1;
            if (k > 0 && !i_cc_tvalid)
                n_err <= n_err + 1;
            if (i_cc_tvalid && o_cc_tready)
            begin
                beat_q.push_back(i_cc_tdata);
                k <= i_cc_tlast ? 0 : k + 1;
                if (k == 1)
                begin
                    o_cid_bus <= i_cc_tdata[24] ? i_cc_tdata[23:16] : CAPT_BUS;
                    o_digest <= i_cc_tdata[31];
                end
            end
        end
    end
endmodule
